// ---- src/asp_engine.v ----
// abort sequence protocol engine: initiator and recipient halves
`timescale 1ns/10ps
`include "asp_regs.vh"
module asp_engine #(
  parameter        CW        = 16,
  parameter        XW        = 16,
  parameter [31:0] RATOV_CYC = `ASP_RATOV_CYC
) (
  input  wire          clk,
  input  wire          rst_n,
  // initiator request and exchange context
  input  wire          abortReq,
  input  wire [7:0]    lastSeqId,
  input  wire [CW-1:0] lastSeqCnt,
  input  wire [1:0]    lastClass,
  input  wire [XW-1:0] curOxId,
  input  wire [XW-1:0] curRxId,
  input  wire [23:0]   lastFctl,
  // received frame header as one cycle strobe
  input  wire          rxValid,
  input  wire [3:0]    rxRctlHi,
  input  wire [3:0]    rxRctlLo,
  input  wire [7:0]    rxType,
  input  wire [7:0]    rxSeqId,
  input  wire [CW-1:0] rxSeqCnt,
  input  wire [1:0]    rxClass,
  input  wire          rxIsData,
  input  wire          rxIsAck,
  input  wire [1:0]    rxAckAbort,
  input  wire [7:0]    rxPayValid,
  input  wire [7:0]    rxPaySeqId,
  input  wire [CW-1:0] rxPayLow,
  input  wire [CW-1:0] rxPayHigh,
  // recipient knowledge of delivered sequences
  input  wire          delivKnown,
  input  wire [7:0]    delivSeqId,
  input  wire [CW-1:0] delivLastCnt,
  input  wire          keepInitiative,
  input  wire          recipAbortReq,
  input  wire          rrqDone,
  input  wire          qualClear,
  // transmit frame
  output reg           txValid,
  output reg  [3:0]    txRctlHi,
  output reg  [3:0]    txRctlLo,
  output reg  [7:0]    txType,
  output reg  [1:0]    txFt,
  output reg  [1:0]    txClass,
  output reg  [7:0]    txSeqId,
  output reg  [CW-1:0] txSeqCnt,
  output reg  [XW-1:0] txOxId,
  output reg  [XW-1:0] txRxId,
  output reg  [23:0]   txFctl,
  output reg  [7:0]    txPayValid,
  output reg  [7:0]    txPaySeqId,
  output reg  [CW-1:0] txPayLow,
  output reg  [CW-1:0] txPayHigh,
  output reg           txHasPayload,
  output reg  [1:0]    txAckAbort,
  // status
  output reg           exchIndet,
  output reg           deliverHold,
  output reg           timersRestart,
  output reg           initQualValid,
  output reg           recipQualValid,
  output reg           rrqSend,
  output reg           dropFrame,
  output reg           txDataBlock,
  output reg           seqAborted,
  output reg           abtsRejected
);
  // ----------------------------------------
  // initiator states
  // ----------------------------------------
  localparam [3:0] I_IDLE = 4'h1;
  localparam [3:0] I_WAIT = 4'h2;
  localparam [3:0] I_RATOV = 4'h4;
  localparam [3:0] I_RRQ = 4'h8;

  reg  [3:0]    iState_q;
  reg  [7:0]    sentSeqId_q;
  reg  [CW-1:0] iLow_q;
  reg  [CW-1:0] iHigh_q;
  reg  [31:0]   timer_q;
  reg  [CW-1:0] abtsCnt_q;
  reg  [7:0]    abtsSeqId_q;
  reg  [1:0]    abtsClass_q;
  reg           rPend_q;
  reg  [CW-1:0] rLow_q;
  reg  [CW-1:0] rHigh_q;
  wire          initHit;
  wire          recipHit;

  function isBls;
    input [3:0] hi;
    input [7:0] ty;
    begin
      isBls = (hi == `ASP_RCTL_BLS) && (ty == `ASP_TYPE_BLS);
    end
  endfunction

  wire rxAbts = rxValid && isBls(rxRctlHi, rxType) && (rxRctlLo == `ASP_CMD_ABTS);
  wire rxAcc  = rxValid && isBls(rxRctlHi, rxType) && (rxRctlLo == `ASP_CMD_BA_ACC);
  wire rxRjt  = rxValid && isBls(rxRctlHi, rxType) && (rxRctlLo == `ASP_CMD_BA_RJT);
  wire [CW-1:0] abtsCntNext = lastSeqCnt + {{(CW-1){1'b0}}, 1'b1};
  // no recovery if counts meet and the echoed id is our last sequence, or if the class is 1
  wire accClean = (rxPayLow == rxPayHigh) && (rxPayValid == `ASP_SEQID_VALID)
                  && (rxPaySeqId == abtsSeqId_q);
  wire accQual  = !accClean && (abtsClass_q != `ASP_CLASS_ONE);

  // ----------------------------------------
  // window checkers
  // ----------------------------------------
  asp_range_chk #(.CW(CW)) uInitChk (
    .clk   (clk),
    .rst_n (rst_n),
    .armed (initQualValid),
    .low   (iLow_q),
    .high  (iHigh_q),
    .cnt   (rxSeqCnt),
    .hit   (initHit)
  );
  asp_range_chk #(.CW(CW)) uRecipChk (
    .clk   (clk),
    .rst_n (rst_n),
    .armed (recipQualValid),
    .low   (rLow_q),
    .high  (rHigh_q),
    .cnt   (rxSeqCnt),
    .hit   (recipHit)
  );
  // checker answers one cycle late, so match against a delayed strobe
  reg rxDataD_q;
  reg rxAckD_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxDataD_q <= 1'b0;
      rxAckD_q  <= 1'b0;
    end else begin
      rxDataD_q <= rxValid && rxIsData;
      rxAckD_q  <= rxValid && (rxIsAck || (rxRctlHi != `ASP_RCTL_BLS && !rxIsData));
    end
  end

  // ----------------------------------------
  // initiator
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iState_q      <= I_IDLE;
      sentSeqId_q   <= 8'h00;
      iLow_q        <= {CW{1'b0}};
      iHigh_q       <= {CW{1'b0}};
      timer_q       <= 32'h0;
      abtsCnt_q     <= {CW{1'b0}};
      abtsSeqId_q   <= 8'h00;
      abtsClass_q   <= 2'h0;
      exchIndet     <= 1'b0;
      deliverHold   <= 1'b0;
      timersRestart <= 1'b0;
      initQualValid <= 1'b0;
      rrqSend       <= 1'b0;
      abtsRejected  <= 1'b0;
    end else begin
      timersRestart <= 1'b0;
      rrqSend       <= 1'b0;
      abtsRejected  <= 1'b0;
      case (iState_q)
        I_IDLE: begin
          // no credit, initiative or open sequence check gates this path
          if (abortReq) begin
            abtsSeqId_q   <= lastSeqId;
            abtsCnt_q     <= abtsCntNext;
            abtsClass_q   <= lastClass;
            exchIndet     <= 1'b1;
            deliverHold   <= 1'b1;
            timersRestart <= 1'b1;
            iState_q      <= I_WAIT;
          end
        end
        I_WAIT: begin
          if (rxAcc) begin
            if (accQual) begin
              iLow_q        <= rxPayLow;
              iHigh_q       <= rxPayHigh;
              initQualValid <= 1'b1;
              timer_q       <= RATOV_CYC;
              iState_q      <= I_RATOV;
            end else begin
              exchIndet   <= 1'b0;
              deliverHold <= 1'b0;
              iState_q    <= I_IDLE;
            end
          end else if (rxRjt) begin
            abtsRejected <= 1'b1;
            exchIndet    <= 1'b0;
            deliverHold  <= 1'b0;
            iState_q     <= I_IDLE;
          end
        end
        I_RATOV: begin
          exchIndet   <= 1'b0;
          deliverHold <= 1'b0;
          if (timer_q <= 32'h1) begin
            rrqSend  <= 1'b1;
            iState_q <= I_RRQ;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        I_RRQ: begin
          if (rrqDone) begin
            initQualValid <= 1'b0;
            iState_q      <= I_IDLE;
          end
        end
        default: begin
          iState_q <= I_IDLE;
        end
      endcase
      sentSeqId_q <= lastSeqId;
    end
  end

  // ----------------------------------------
  // recipient
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rPend_q        <= 1'b0;
      rLow_q         <= {CW{1'b0}};
      rHigh_q        <= {CW{1'b0}};
      recipQualValid <= 1'b0;
      seqAborted     <= 1'b0;
    end else begin
      seqAborted <= 1'b0;
      // unless the idle initiator sends its own ABTS that cycle, accept is sent two cycles after ABTS without waiting on timeouts
      rPend_q <= rxAbts;
      if (rxAbts) begin
        rHigh_q <= rxSeqCnt;
        rLow_q  <= delivKnown ? delivLastCnt : {CW{1'b0}};
        seqAborted <= !(delivKnown && delivSeqId == rxSeqId && delivLastCnt == rxSeqCnt);
        if (rxClass != `ASP_CLASS_ONE && !(delivKnown && delivSeqId == rxSeqId))
          recipQualValid <= 1'b1;
      end else if (qualClear) begin
        recipQualValid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // transmit and discard
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txValid      <= 1'b0;
      txRctlHi     <= 4'h0;
      txRctlLo     <= 4'h0;
      txType       <= 8'h00;
      txFt         <= 2'h0;
      txClass      <= 2'h0;
      txSeqId      <= 8'h00;
      txSeqCnt     <= {CW{1'b0}};
      txOxId       <= {XW{1'b0}};
      txRxId       <= {XW{1'b0}};
      txFctl       <= 24'h0;
      txPayValid   <= 8'h00;
      txPaySeqId   <= 8'h00;
      txPayLow     <= {CW{1'b0}};
      txPayHigh    <= {CW{1'b0}};
      txHasPayload <= 1'b0;
      txAckAbort   <= 2'h0;
      dropFrame    <= 1'b0;
      txDataBlock  <= 1'b0;
    end else begin
      txValid    <= 1'b0;
      txAckAbort <= recipAbortReq ? `ASP_ACK_ABORT_SEQ : 2'h0;
      if (iState_q == I_IDLE && abortReq) begin
        txValid      <= 1'b1;
        txRctlHi     <= `ASP_RCTL_BLS;
        txRctlLo     <= `ASP_CMD_ABTS;
        txType       <= `ASP_TYPE_BLS;
        txFt         <= `ASP_FT_ONE;
        txHasPayload <= 1'b0;
        txClass      <= lastClass;
        txSeqId      <= lastSeqId;
        txSeqCnt     <= abtsCntNext;
        txOxId       <= curOxId;
        txRxId       <= curRxId;
        txFctl       <= lastFctl | (24'h1 << `ASP_FCTL_END_SEQ) | (24'h1 << `ASP_FCTL_SEQ_INIT);
      end else if (rPend_q) begin
        txValid      <= 1'b1;
        txRctlHi     <= `ASP_RCTL_BLS;
        txRctlLo     <= `ASP_CMD_BA_ACC;
        txType       <= `ASP_TYPE_BLS;
        txFt         <= `ASP_FT_ONE;
        txHasPayload <= 1'b1;
        txSeqCnt     <= rHigh_q;
        txFctl       <= keepInitiative ? 24'h0 : (24'h1 << `ASP_FCTL_SEQ_INIT);
        txPayValid   <= delivKnown ? `ASP_SEQID_VALID : `ASP_SEQID_INVALID;
        txPaySeqId   <= delivKnown ? delivSeqId : 8'h00;
        txPayLow     <= rLow_q;
        txPayHigh    <= rHigh_q;
      end
      dropFrame   <= (rxDataD_q && recipHit && recipQualValid)
                  || (rxAckD_q && initHit && initQualValid);
      txDataBlock <= initQualValid;
    end
  end
endmodule

// ---- src/asp_range_chk.v ----
// window test of a sequence count against a low/high range
`timescale 1ns/10ps
module asp_range_chk #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          armed,
  input  wire [CW-1:0] low,
  input  wire [CW-1:0] high,
  input  wire [CW-1:0] cnt,
  output reg           hit
);
  // inclusive window; zero low with wrap is out of scope of this engine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else begin
      hit <= armed && (cnt >= low) && (cnt <= high);
    end
  end
endmodule

// ---- src/asp_regs.vh ----
// constants for the abort sequence protocol engine
// Operation
// - recipient asks abort via ACK bits 01
// - ABTS sent regardless of initiative holder
// - ABTS reuses last sent SEQ_ID
// - ABTS uses class of last sequence
// - ABTS carries current OX_ID and RX_ID
// - copy F_CTL bits, set SI, ES
// - ABTS allowed without credit or initiative
// - exchange indeterminate, delivery held until accept
// - restart E_D_TOV and R_A_TOV on ABTS
// - recipient computes SEQ_CNT error range
// - recipient may deliver frames until accept
// - accept atomic; discard data in range
// - accept need not wait for timeouts
// - accept F_CTL bit16 shows initiative holder
// - accept SEQ_ID validity marks last deliverable
// - low = last deliverable cnt, high = ABTS cnt
// - equal counts and matching ID: no recovery; the recipient forms no qualifier on a matching ID alone, whatever the counts
// - class 1 forms no recovery qualifier
// - class 2/3 error: qualifier, drop ACKs
// - initiator sends no data within qualifier
// - wait R_A_TOV after accept, then RRQ
// - ABTS is FT 1, no payload
// - ABTS SEQ_CNT is previous plus one
// - routing bits 1000, TYPE zero
// - command code ABTS 0001, accept 0100
// - basic reject reply also recognised
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
// ----------------------------------------
// frame encodings
// ----------------------------------------
`define ASP_RCTL_BLS      4'h8
`define ASP_CMD_ABTS      4'h1
`define ASP_CMD_BA_ACC    4'h4
`define ASP_CMD_BA_RJT    4'h5
`define ASP_TYPE_BLS      8'h00
`define ASP_FT_ONE        2'h1
`define ASP_ACK_ABORT_SEQ 2'h1
`define ASP_SEQID_VALID   8'h80
`define ASP_SEQID_INVALID 8'h00
`define ASP_CLASS_ONE     2'h1
// ----------------------------------------
// f_ctl bit positions
// ----------------------------------------
`define ASP_FCTL_END_SEQ  19
`define ASP_FCTL_SEQ_INIT 16
// ----------------------------------------
// timing
// ----------------------------------------
`define ASP_CLK_NS        25
`define ASP_RATOV_MS      10000
// divide first: ms * 1e6 overflows 32-bit integer arithmetic
`define ASP_RATOV_CYC     (`ASP_RATOV_MS * (1000000 / `ASP_CLK_NS))
`endif

// ---- verif/asp_engine_properties.sv ----
// concurrent checks on the abort sequence engine ports
`timescale 1ns/10ps
`include "asp_regs.vh"
module asp_chk #(
  parameter CW = 16
) (
  input wire          clk, rst_n, abortReq, rxValid, keepInitiative, recipAbortReq, txValid,
  input wire          txHasPayload, exchIndet, deliverHold, timersRestart, initQualValid, txDataBlock,
  input wire [1:0]    lastClass, txFt, txClass, txAckAbort,
  input wire [3:0]    rxRctlHi, rxRctlLo, txRctlHi, txRctlLo,
  input wire [7:0]    lastSeqId, txSeqId,
  input wire [CW-1:0] lastSeqCnt, rxSeqCnt, txSeqCnt, txPayHigh,
  input wire [23:0]   lastFctl, txFctl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a busy initiator ignores the request, so only idle requests count
  wire abtsGo = abortReq && !exchIndet && !initQualValid;
  wire abtsIn = rxValid && rxRctlHi == `ASP_RCTL_BLS && rxRctlLo == `ASP_CMD_ABTS;

  abts_hdr_a: assert property (
    abtsGo |=> txValid && txRctlHi == `ASP_RCTL_BLS && txRctlLo == `ASP_CMD_ABTS && txFt == `ASP_FT_ONE && !txHasPayload)
    else $error("abort frame header wrong");
  abts_ids_a: assert property (
    abtsGo |=> txSeqId == $past(lastSeqId) && txSeqCnt == CW'($past(lastSeqCnt) + 1'b1) && txClass == $past(lastClass))
    else $error("abort frame sequence fields wrong");
  abts_fctl_a: assert property (
    abtsGo |=> txFctl == ($past(lastFctl) | 24'h090000)) else $error("abort frame control bits wrong");
  abts_indet_a: assert property (
    abtsGo |=> exchIndet && deliverHold && timersRestart) else $error("exchange not held after abort");
  indet_hold_a: assert property (
    exchIndet |-> deliverHold) else $error("delivery released while indeterminate");
  acc_reply_a: assert property (
    abtsIn ##1 !abortReq |=> txValid && txRctlLo == `ASP_CMD_BA_ACC && txPayHigh == $past(rxSeqCnt, 2))
    else $error("accept missing or high count wrong");
  acc_init_a: assert property (
    abtsIn ##1 !abortReq |=> txFctl[16] == !keepInitiative) else $error("accept initiative bit wrong");
  ack_abort_a: assert property (
    recipAbortReq |=> txAckAbort == `ASP_ACK_ABORT_SEQ) else $error("ack abort field wrong");
  qual_block_a: assert property (
    txDataBlock == $past(initQualValid)) else $error("data block does not follow qualifier");
endmodule

bind asp_engine asp_chk #(.CW(CW)) u_asp_chk (.*);

// ---- verif/asp_peer_model.sv ----
// peer port model: answers abort frames and sends frames on command
`timescale 1ns/10ps
`include "asp_regs.vh"
module asp_peer #(
  parameter CW = 16
) (
  input  wire          clk, txValid,
  input  wire [3:0]    txRctlLo,
  input  wire [7:0]    txSeqId,
  input  wire [CW-1:0] txSeqCnt,
  input  wire [1:0]    txClass,
  output reg           rxValid, rxIsData, rxIsAck,
  output reg  [3:0]    rxRctlHi, rxRctlLo,
  output reg  [7:0]    rxType, rxSeqId, rxPayValid, rxPaySeqId,
  output reg  [1:0]    rxClass, rxAckAbort,
  output reg  [CW-1:0] rxSeqCnt, rxPayLow, rxPayHigh
);
  reg     [1:0] replyMode;
  integer       replyDelay;

  task send(input [3:0] hi, input [3:0] lo, input [1:0] cls, input data, input [7:0] id,
            input [CW-1:0] cnt, input [CW-1:0] low);
    begin
      @(posedge clk);
      #1;
      {rxRctlHi, rxRctlLo, rxClass, rxIsData, rxSeqId} = {hi, lo, cls, data, id};
      {rxSeqCnt, rxPayLow, rxPayHigh, rxPayValid, rxPaySeqId} = {cnt, low, cnt, 8'h80, id};
      rxType = (hi == `ASP_RCTL_BLS) ? `ASP_TYPE_BLS : 8'h08;
      rxValid = 1'b1;
      @(posedge clk);
      #1;
      rxValid = 1'b0;
      // released fields turn over so stale values never pass as fresh
      {rxSeqId, rxSeqCnt, rxPayLow, rxPayHigh} = ~{rxSeqId, rxSeqCnt, rxPayLow, rxPayHigh};
    end
  endtask

  // ----------------------------------------
  // reply to abort: mode 0 clean, 1 error range, 2 reject
  // ----------------------------------------
  initial begin
    {rxValid, rxIsData, rxIsAck, rxRctlHi, rxRctlLo, rxType, rxSeqId, rxPayValid, rxPaySeqId} = '0;
    {rxClass, rxAckAbort, rxSeqCnt, rxPayLow, rxPayHigh} = '0;
    replyMode = 2'h1;
    replyDelay = 2;
    forever begin
      @(posedge clk);
      // look after the edge so the frame just launched is settled
      #1;
      if (txValid && txRctlLo == `ASP_CMD_ABTS) begin
        repeat (replyDelay) @(posedge clk);
        send(`ASP_RCTL_BLS, replyMode == 2'h2 ? `ASP_CMD_BA_RJT : `ASP_CMD_BA_ACC, txClass, 1'b0, txSeqId,
             txSeqCnt, replyMode == 2'h1 ? txSeqCnt - 3 : txSeqCnt);
      end
    end
  end
endmodule

// ---- verif/asp_tb.sv ----
// self-checking bench for the abort sequence engine
`timescale 1ns/10ps
`include "asp_regs.vh"
module testbench;
  localparam CW    = 16;
  localparam RATOV = 20;
  reg           clk, rst_n, abortReq, delivKnown, keepInitiative, recipAbortReq, rrqDone, qualClear;
  reg  [7:0]    lastSeqId, delivSeqId;
  reg  [CW-1:0] lastSeqCnt, delivLastCnt;
  reg  [1:0]    lastClass;
  reg  [15:0]   curOxId, curRxId;
  reg  [23:0]   lastFctl;
  wire          txValid, txHasPayload, exchIndet, deliverHold, timersRestart, initQualValid, recipQualValid;
  wire          rrqSend, dropFrame, txDataBlock, seqAborted, abtsRejected, rxValid, rxIsData, rxIsAck;
  wire [3:0]    txRctlHi, txRctlLo, rxRctlHi, rxRctlLo;
  wire [1:0]    txFt, txClass, txAckAbort, rxClass, rxAckAbort;
  wire [7:0]    txType, txSeqId, txPayValid, txPaySeqId, rxType, rxSeqId, rxPayValid, rxPaySeqId;
  wire [CW-1:0] txSeqCnt, txPayLow, txPayHigh, rxSeqCnt, rxPayLow, rxPayHigh;
  wire [15:0]   txOxId, txRxId;
  wire [23:0]   txFctl;
  integer       nFail, samplesChecked, n;

  asp_engine #(.CW(CW), .XW(16), .RATOV_CYC(RATOV)) u_asp_engine (.*);
  asp_peer #(.CW(CW)) u_asp_peer (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task tick;
    begin
      @(posedge clk);
      #2;
    end
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== exp) begin
        nFail = nFail + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task printVerdict;
    begin
      if (nFail == 0 && samplesChecked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------
  // initiator: abort, peer reply, qualifier, delayed reinstate
  // ----------------------------------------
  task abtsRun(input [1:0] cls, input [1:0] mode, input integer dly);
    reg q;
    begin
      q = (mode == 2'h1) && (cls != `ASP_CLASS_ONE);
      u_asp_peer.replyMode = mode;
      u_asp_peer.replyDelay = dly;
      {lastSeqId, lastSeqCnt, lastClass} = {8'h30 + cls, 16'h0040 + mode, cls};
      tick;
      abortReq = 1'b1;
      tick;
      abortReq = 1'b0;
      chk("abts valid", {txValid, txSeqId, txClass}, {1'b1, lastSeqId, cls});
      chk("abts ids", {txOxId, txRxId}, {curOxId, curRxId});
      chk("abts hdr", {txType, txFt, txHasPayload, txRctlHi, txRctlLo}, {8'h00, 2'h1, 1'b0, 4'h8, 4'h1});
      chk("abts count", txSeqCnt, lastSeqCnt + 16'h0001);
      chk("abts fctl", txFctl, lastFctl | 24'h090000);
      chk("abts hold", {exchIndet, deliverHold, timersRestart}, 3'h7);
      for (n = 0; n < 40 && rxValid !== 1'b1; n = n + 1)
        tick;
      tick;
      chk("qual formed", initQualValid, q);
      chk("reject seen", abtsRejected, mode == 2'h2);
      tick;
      chk("after reply", {txDataBlock, exchIndet, deliverHold}, {q, 2'h0});
      if (q) begin
        u_asp_peer.send(4'hc, 4'h0, cls, 1'b0, lastSeqId, lastSeqCnt, 16'h0000);
        tick;
        chk("ack dropped", dropFrame, 1'b1);
        n = 5;
        while (rrqSend !== 1'b1 && n < RATOV + 8) begin
          tick;
          n = n + 1;
        end
        chk("rrq wait", n >= RATOV && n <= RATOV + 3, 1'b1);
        rrqDone = 1'b1;
        tick;
        rrqDone = 1'b0;
        tick;
        chk("qual cleared", {initQualValid, txDataBlock}, 2'h0);
      end
    end
  endtask

  // ----------------------------------------
  // recipient: accept payload and discard window
  // ----------------------------------------
  task recipRun(input known, input keep);
    begin
      {delivKnown, keepInitiative, delivSeqId, delivLastCnt} = {known, keep, 8'h11, 16'h0010};
      u_asp_peer.send(4'h8, `ASP_CMD_ABTS, 2'h2, 1'b0, 8'h12, 16'h0020, 16'h0000);
      chk("recip abort", {recipQualValid, seqAborted}, 2'h3);
      tick;
      chk("acc cmd", {txValid, txRctlHi, txRctlLo, txFctl[16]}, {1'b1, 8'h84, !keep});
      chk("acc valid", txPayValid, known ? 8'h80 : 8'h00);
      chk("acc range", {txPayLow, txPayHigh}, {known ? 16'h0010 : 16'h0000, 16'h0020});
      if (known)
        chk("acc id", txPaySeqId, 8'h11);
      u_asp_peer.send(4'h0, 4'h0, 2'h2, 1'b1, 8'h12, 16'h0015, 16'h0000);
      tick;
      chk("in range drop", dropFrame, 1'b1);
      u_asp_peer.send(4'h0, 4'h0, 2'h2, 1'b1, 8'h12, 16'h0030, 16'h0000);
      tick;
      chk("out range kept", dropFrame, 1'b0);
      qualClear = 1'b1;
      tick;
      qualClear = 1'b0;
      u_asp_peer.send(4'h0, 4'h0, 2'h2, 1'b1, 8'h12, 16'h0015, 16'h0000);
      tick;
      chk("cleared kept", {recipQualValid, dropFrame}, 2'h0);
    end
  endtask

  task ackAbortRun;
    begin
      recipAbortReq = 1'b1;
      tick;
      chk("ack abort", txAckAbort, 2'h1);
      recipAbortReq = 1'b0;
      tick;
      chk("ack plain", txAckAbort, 2'h0);
    end
  endtask

  initial begin
    {rst_n, abortReq, delivKnown, keepInitiative, recipAbortReq, rrqDone, qualClear} = 7'h00;
    {lastSeqId, lastSeqCnt, lastClass, delivSeqId, delivLastCnt} = 50'h0;
    {curOxId, curRxId, lastFctl} = {16'h1a2b, 16'h3c4d, 24'h200005};
    nFail = 0;
    samplesChecked = 0;
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    tick;
    abtsRun(2'h2, 2'h1, 0);
    abtsRun(2'h3, 2'h1, 6);
    abtsRun(2'h1, 2'h1, 2);
    abtsRun(2'h2, 2'h0, 2);
    abtsRun(2'h2, 2'h2, 3);
    recipRun(1'b1, 1'b1);
    recipRun(1'b1, 1'b0);
    recipRun(1'b0, 1'b0);
    ackAbortRun;
    printVerdict;
  end

  initial begin
    repeat (4000) @(posedge clk);
    nFail = nFail + 1;
    printVerdict;
  end
endmodule
